// [hdl/pwrdn_pkg.sv]
// Package of constants and carriers for the power-down mode controller.
// Assumes one 40 MHz system clock and an 8-bit register port.
package pwrdn_pkg;

	// Register offsets
	localparam logic [3:0] OFS_SLEEP_CTL  = 4'h0;
	localparam logic [3:0] OFS_SYS_CTL    = 4'h1;
	localparam logic [3:0] OFS_STOP_HI    = 4'h2;
	localparam logic [3:0] OFS_STOP_LO    = 4'h3;
	localparam logic [3:0] OFS_STOP_SUB   = 4'h4;
	localparam logic [3:0] OFS_LOWPWR_CTL = 4'h5;
	localparam logic [3:0] OFS_WDOG_CTL   = 4'h6;
	localparam logic [3:0] OFS_STATUS     = 4'h7;

	// Field positions
	localparam int BIT_SLEEP_SEL  = 7;
	localparam int BIT_STS_LO     = 4;
	localparam int BIT_NMI_EDGE   = 3;
	localparam int BIT_RAM_EN     = 0;
	localparam int BIT_SUBCLK_EN  = 4;
	localparam int BIT_PRESCALER  = 6;
	localparam int BIT_SETTLED    = 3;
	localparam int BIT_XFER_CTL   = 14;
	localparam int NUM_MODULES    = 24;

	// Reset values
	localparam logic [7:0]  RST_STOP_HI  = 8'h3F;
	localparam logic [7:0]  RST_STOP_LO  = 8'hFF;
	localparam logic [7:0]  RST_STOP_SUB = 8'hFF;
	localparam logic [2:0]  RST_STS      = 3'h0;
	// PWM timer, A/D converter and two serial channels lose state
	localparam logic [23:0] INIT_MASK    = 24'h000AC0;

	// Settling time table, in microseconds, one per field value
	localparam int SETTLE_US [8] = '{8, 16, 32, 64, 128, 256, 512, 16};
	localparam int CLK_MHZ = 40;
	localparam int CNT_W   = 16;

	typedef enum logic [2:0] {
		ST_RUN    = 3'b000,
		ST_SLEEP  = 3'b001,
		ST_SWSTBY = 3'b010,
		ST_SETTLE = 3'b011,
		ST_RESET  = 3'b100,
		ST_HWSTBY = 3'b101
	} mode_e;

	// Pins from the outside world, all asynchronous
	typedef struct packed {
		logic        resetPin_n;
		logic        standbyPin_n;
		logic        nmiPin;
		logic [15:0] extIrq;
		logic [2:0]  modePins;
	} pins_s;

	// Control register contents
	typedef struct packed {
		logic       standbySelect;
		logic [2:0] settlingTime;
		logic       nmiEdgeSelect;
		logic       ramEnable;
		logic       subclockEnable;
		logic       prescalerSelect;
	} ctl_s;

endpackage : pwrdn_pkg

// [hdl/settle_timer.sv]
// Oscillation settling counter with a table of terminal counts.
// Assumes run is high for the whole wait and drops after it.
`timescale 1ns/1ps
module settle_timer #(
	parameter int CNT_W = pwrdn_pkg::CNT_W,
	parameter logic [7:0][15:0] TABLE = '{
		16'(pwrdn_pkg::SETTLE_US[7] * pwrdn_pkg::CLK_MHZ),
		16'(pwrdn_pkg::SETTLE_US[6] * pwrdn_pkg::CLK_MHZ),
		16'(pwrdn_pkg::SETTLE_US[5] * pwrdn_pkg::CLK_MHZ),
		16'(pwrdn_pkg::SETTLE_US[4] * pwrdn_pkg::CLK_MHZ),
		16'(pwrdn_pkg::SETTLE_US[3] * pwrdn_pkg::CLK_MHZ),
		16'(pwrdn_pkg::SETTLE_US[2] * pwrdn_pkg::CLK_MHZ),
		16'(pwrdn_pkg::SETTLE_US[1] * pwrdn_pkg::CLK_MHZ),
		16'(pwrdn_pkg::SETTLE_US[0] * pwrdn_pkg::CLK_MHZ)}
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// Control
	input  wire logic       run,
	input  wire logic [2:0] sel,
	// Status
	output logic            done
);

	logic [CNT_W-1:0] count;

	// Count while running, clear when idle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			done  <= 1'b0;
		end else if (ce) begin
			if (!run) begin
				count <= '0;
				done  <= 1'b0;
			end else if (count >= CNT_W'(TABLE[sel])) begin
				done  <= 1'b1;
			end else begin
				count <= count + CNT_W'(1);
			end
		end
	end

endmodule : settle_timer

// [hdl/power_down_mode_control.sv]
// Power-down mode controller: sleep, standby modes and module stop.
// Assumes CPU strobes on mclk; pins arrive asynchronously.
`timescale 1ns/1ps
module power_down_mode_control #(
	parameter int NMOD = pwrdn_pkg::NUM_MODULES
) (
	// Clock, reset, enable
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	input  wire logic                  ce,
	// External pins
	input  wire pwrdn_pkg::pins_s      pins,
	// CPU side
	input  wire logic                  sleepExec,
	input  wire logic                  intAccepted,
	input  wire logic                  cpuIntMask,
	input  wire logic [15:0]           irqEnable,
	input  wire logic                  mediumSpeedSel,
	input  wire logic                  busCycleEnd,
	input  wire logic                  xferBusReq,
	// Register port
	input  wire logic [3:0]            regAddr,
	input  wire logic [7:0]            regWrData,
	input  wire logic                  regWr,
	input  wire logic                  regRd,
	output logic [7:0]                 regRdData,
	// Mode outputs
	output pwrdn_pkg::mode_e           mode,
	output logic                       cpuHalt,
	output logic                       sysClkRun,
	output logic                       chipReset,
	output logic                       ioHighZ,
	output logic                       intExcStart,
	output logic                       resetExcStart,
	output logic                       mediumSpeed,
	output logic [2:0]                 bootMode,
	output pwrdn_pkg::ctl_s            ctl,
	// Peripheral control
	output logic [NMOD-1:0]            periphHalt,
	output logic [NMOD-1:0]            periphInit,
	output logic [NMOD-1:0]            periphRegEn
);

	pwrdn_pkg::pins_s  syncA;
	pwrdn_pkg::pins_s  syncB;
	pwrdn_pkg::mode_e  next_mode;
	logic              nmiPrev;
	logic              nmiEdge;
	logic              extWake;
	logic              settled;
	logic              settleRun;
	logic [NMOD-1:0]   stopReg;
	logic [NMOD-1:0]   stopApplied;
	logic              medBeforeSleep;

	// Register decode, used for writes; reads decode the address with a case
	function automatic logic hit(input logic [3:0] a,
		input logic [3:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// Two-flop synchroniser for every pin
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			syncA <= '{resetPin_n: 1'b1, standbyPin_n: 1'b1, default: '0};
			syncB <= '{resetPin_n: 1'b1, standbyPin_n: 1'b1, default: '0};
		end else if (ce) begin
			syncA <= pins;
			syncB <= syncA;
		end
	end

	// NMI edge history
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			nmiPrev <= 1'b0;
		end else if (ce) begin
			nmiPrev <= syncB.nmiPin;
		end
	end

	// Edge chosen by the edge select bit
	assign nmiEdge = ctl.nmiEdgeSelect ? (syncB.nmiPin & ~nmiPrev)
		: (~syncB.nmiPin & nmiPrev);
	// NMI edge or enabled, unmasked IRQs wake software standby
	assign extWake = nmiEdge
		| (|(syncB.extIrq & irqEnable) & ~cpuIntMask);

	// Next mode, pin-driven changes first
	always_comb begin
		next_mode = mode;
		if (!syncB.standbyPin_n) begin
			next_mode = pwrdn_pkg::ST_HWSTBY;
		end else if (mode == pwrdn_pkg::ST_HWSTBY) begin
			next_mode = pwrdn_pkg::ST_RESET;
		end else if (!syncB.resetPin_n) begin
			next_mode = pwrdn_pkg::ST_RESET;
		end else begin
			unique case (mode)
				pwrdn_pkg::ST_RUN: begin
					if (sleepExec && !ctl.standbySelect) begin
						next_mode = pwrdn_pkg::ST_SLEEP;
					end else if (sleepExec && !ctl.prescalerSelect) begin
						next_mode = pwrdn_pkg::ST_SWSTBY;
					end
				end
				pwrdn_pkg::ST_SLEEP: begin
					if (intAccepted || nmiEdge) begin
						next_mode = pwrdn_pkg::ST_RUN;
					end
				end
				pwrdn_pkg::ST_SWSTBY: begin
					if (extWake) begin
						next_mode = pwrdn_pkg::ST_SETTLE;
					end
				end
				pwrdn_pkg::ST_SETTLE: begin
					if (settled) begin
						next_mode = pwrdn_pkg::ST_RUN;
					end
				end
				pwrdn_pkg::ST_RESET: begin
					if (settled) begin
						next_mode = pwrdn_pkg::ST_RUN;
					end
				end
				default: next_mode = pwrdn_pkg::ST_RESET;
			endcase
		end
	end

	// Mode register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= pwrdn_pkg::ST_RESET;
		end else if (ce) begin
			mode <= next_mode;
		end
	end

	// Exception start pulses on the way back to running
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			intExcStart   <= 1'b0;
			resetExcStart <= 1'b0;
		end else if (ce) begin
			intExcStart   <= next_mode == pwrdn_pkg::ST_RUN
				&& (mode == pwrdn_pkg::ST_SLEEP
				|| mode == pwrdn_pkg::ST_SETTLE);
			resetExcStart <= next_mode == pwrdn_pkg::ST_RUN
				&& mode == pwrdn_pkg::ST_RESET;
		end
	end

	// Remember medium speed across sleep
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			medBeforeSleep <= 1'b0;
		end else if (ce && mode == pwrdn_pkg::ST_RUN) begin
			medBeforeSleep <= mediumSpeedSel;
		end
	end
	assign mediumSpeed = (mode == pwrdn_pkg::ST_RUN) & medBeforeSleep;

	// Mode pins sampled every cycle of reset handling; the last value is kept
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bootMode <= 3'h0;
		end else if (ce && mode == pwrdn_pkg::ST_RESET) begin
			bootMode <= syncB.modePins;
		end
	end

	// Settling counter runs on the restarted clock
	assign settleRun = (mode == pwrdn_pkg::ST_SETTLE)
		| (mode == pwrdn_pkg::ST_RESET);
	settle_timer u_settle (
		.mclk (mclk),
		.rst_n(rst_n),
		.ce   (ce),
		.run  (settleRun),
		.sel  (ctl.settlingTime),
		.done (settled)
	);

	// Mode-derived chip controls
	assign cpuHalt   = mode != pwrdn_pkg::ST_RUN;
	assign sysClkRun = (mode != pwrdn_pkg::ST_SWSTBY)
		& (mode != pwrdn_pkg::ST_HWSTBY);
	assign chipReset = (mode == pwrdn_pkg::ST_RESET)
		| (mode == pwrdn_pkg::ST_HWSTBY);
	assign ioHighZ   = mode == pwrdn_pkg::ST_HWSTBY;

	// Control registers, cleared by hardware standby
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctl <= '{ramEnable: 1'b1, settlingTime: pwrdn_pkg::RST_STS,
				default: '0};
		end else if (ce && mode == pwrdn_pkg::ST_HWSTBY) begin
			ctl <= '{ramEnable: 1'b1, settlingTime: pwrdn_pkg::RST_STS,
				default: '0};
		end else if (ce && regWr) begin
			if (hit(regAddr, pwrdn_pkg::OFS_SLEEP_CTL)) begin
				ctl.standbySelect <= regWrData[pwrdn_pkg::BIT_SLEEP_SEL];
				ctl.settlingTime  <=
					regWrData[pwrdn_pkg::BIT_STS_LO +: 3];
			end
			if (hit(regAddr, pwrdn_pkg::OFS_SYS_CTL)) begin
				ctl.nmiEdgeSelect <= regWrData[pwrdn_pkg::BIT_NMI_EDGE];
				ctl.ramEnable     <= regWrData[pwrdn_pkg::BIT_RAM_EN];
			end
			if (hit(regAddr, pwrdn_pkg::OFS_LOWPWR_CTL)) begin
				ctl.subclockEnable <= regWrData[pwrdn_pkg::BIT_SUBCLK_EN];
			end
			if (hit(regAddr, pwrdn_pkg::OFS_WDOG_CTL)) begin
				ctl.prescalerSelect <= regWrData[pwrdn_pkg::BIT_PRESCALER];
			end
		end
	end

	// Module stop bits as written by software
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stopReg <= {pwrdn_pkg::RST_STOP_SUB, pwrdn_pkg::RST_STOP_HI,
				pwrdn_pkg::RST_STOP_LO};
		end else if (ce && chipReset) begin
			stopReg <= {pwrdn_pkg::RST_STOP_SUB, pwrdn_pkg::RST_STOP_HI,
				pwrdn_pkg::RST_STOP_LO};
		end else if (ce && regWr) begin
			if (hit(regAddr, pwrdn_pkg::OFS_STOP_HI)) begin
				stopReg[15:8] <= regWrData;
				// Controller owns the bus: its stop bit keeps 0
				if (xferBusReq && !stopReg[pwrdn_pkg::BIT_XFER_CTL]) begin
					stopReg[pwrdn_pkg::BIT_XFER_CTL] <= 1'b0;
				end
			end
			if (hit(regAddr, pwrdn_pkg::OFS_STOP_LO)) begin
				stopReg[7:0] <= regWrData;
			end
			if (hit(regAddr, pwrdn_pkg::OFS_STOP_SUB)) begin
				stopReg[23:16] <= regWrData;
			end
		end
	end

	// Stop bits take effect at the end of a bus cycle or during chip reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stopApplied <= {pwrdn_pkg::RST_STOP_SUB, pwrdn_pkg::RST_STOP_HI,
				pwrdn_pkg::RST_STOP_LO};
		end else if (ce && (busCycleEnd || chipReset)) begin
			stopApplied <= stopReg;
		end
	end

	// Per-module halt, init and register gating
	for (genvar i = 0; i < NMOD; i++) begin : g_mod
		assign periphHalt[i]  = stopApplied[i] | ~sysClkRun;
		assign periphInit[i]  = chipReset
			| (pwrdn_pkg::INIT_MASK[i] & periphHalt[i]);
		assign periphRegEn[i] = ~stopApplied[i];
	end

	// Read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= 8'h00;
		end else if (ce && regRd) begin
			unique case (regAddr)
				pwrdn_pkg::OFS_SLEEP_CTL: regRdData <=
					{ctl.standbySelect, ctl.settlingTime, 4'h0};
				pwrdn_pkg::OFS_SYS_CTL: regRdData <= {4'h0,
					ctl.nmiEdgeSelect, 2'h0, ctl.ramEnable};
				pwrdn_pkg::OFS_STOP_HI: regRdData <= stopReg[15:8];
				pwrdn_pkg::OFS_STOP_LO: regRdData <= stopReg[7:0];
				pwrdn_pkg::OFS_STOP_SUB: regRdData <= stopReg[23:16];
				pwrdn_pkg::OFS_LOWPWR_CTL: regRdData <=
					{3'h0, ctl.subclockEnable, 4'h0};
				pwrdn_pkg::OFS_WDOG_CTL: regRdData <=
					{1'h0, ctl.prescalerSelect, 6'h00};
				pwrdn_pkg::OFS_STATUS: regRdData <=
					{4'h0, settled, mode};
				default: regRdData <= 8'h00;
			endcase
		end
	end

	// Checks on the mode sequencing
	sequence sw_wake_s;
		ce && mode == pwrdn_pkg::ST_SWSTBY && extWake
			&& syncB.standbyPin_n && syncB.resetPin_n;
	endsequence

	sequence settle_done_s;
		ce && mode == pwrdn_pkg::ST_SETTLE && settled
			&& syncB.standbyPin_n && syncB.resetPin_n;
	endsequence

	hwstby_entry_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && !syncB.standbyPin_n |=> mode == pwrdn_pkg::ST_HWSTBY)
		else $error("standby pin did not force hardware standby");

	sleep_entry_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && mode == pwrdn_pkg::ST_RUN && sleepExec && !ctl.standbySelect
		&& syncB.standbyPin_n && syncB.resetPin_n
		|=> mode == pwrdn_pkg::ST_SLEEP && cpuHalt)
		else $error("sleep not entered");

	swstby_entry_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && mode == pwrdn_pkg::ST_RUN && sleepExec && ctl.standbySelect
		&& !ctl.prescalerSelect && syncB.standbyPin_n
		&& syncB.resetPin_n
		|=> mode == pwrdn_pkg::ST_SWSTBY && !sysClkRun)
		else $error("software standby not entered");

	sleep_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && mode == pwrdn_pkg::ST_SLEEP && !intAccepted && !nmiEdge
		&& syncB.standbyPin_n && syncB.resetPin_n
		|=> mode == pwrdn_pkg::ST_SLEEP && !intExcStart)
		else $error("sleep left without interrupt");

	masked_irq_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && mode == pwrdn_pkg::ST_SWSTBY && !nmiEdge && cpuIntMask
		&& syncB.standbyPin_n && syncB.resetPin_n
		|=> mode == pwrdn_pkg::ST_SWSTBY)
		else $error("masked irq woke software standby");

	settle_exit_a: assert property (@(posedge mclk) disable iff (!rst_n)
		settle_done_s |=> intExcStart && mode == pwrdn_pkg::ST_RUN)
		else $error("settling wait did not end in interrupt handling");

	swstby_wake_a: assert property (@(posedge mclk) disable iff (!rst_n)
		sw_wake_s |=> mode == pwrdn_pkg::ST_SETTLE && sysClkRun)
		else $error("wake request did not start settling");

	reset_clock_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && mode == pwrdn_pkg::ST_SWSTBY && !syncB.resetPin_n
		&& syncB.standbyPin_n |=> sysClkRun && chipReset)
		else $error("reset did not restart clock");

	hw_float_a: assert property (@(posedge mclk) disable iff (!rst_n)
		mode == pwrdn_pkg::ST_HWSTBY |-> ioHighZ && chipReset
		&& (&periphInit))
		else $error("hardware standby outputs wrong");

	xfer_collide_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && !chipReset && regWr && hit(regAddr, pwrdn_pkg::OFS_STOP_HI)
		&& xferBusReq && !stopReg[pwrdn_pkg::BIT_XFER_CTL]
		|=> !stopReg[pwrdn_pkg::BIT_XFER_CTL])
		else $error("stop bit set during controller bus request");

	stop_timing_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ce && !busCycleEnd && !chipReset |=> $stable(stopApplied))
		else $error("module stop changed outside bus cycle end");

	edge_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
		nmiEdge |-> syncB.nmiPin == ctl.nmiEdgeSelect)
		else $error("nmi edge against edge select");

endmodule : power_down_mode_control

// [bench/pin_partner.sv]
// Model of the reset, standby, interrupt and mode pins.
// Assumes mode and clock-run status come from the controller.
`timescale 1ns/1ps
module pin_partner #(
	parameter int SETTLE_CYC = 330
) (
	// Clock and observed state
	input  wire logic             mclk,
	input  wire pwrdn_pkg::mode_e mode,
	input  wire logic             sysClkRun,
	// Pins into the controller
	output pwrdn_pkg::pins_s      pins
);
	// Idle levels: no reset, no standby, no requests
	initial pins = {1'b1, 1'b1, 1'b0, 16'h0000, 3'h2};

	// Reset pin low
	task automatic resetLow;
		@(posedge mclk);
		pins.resetPin_n <= 1'b0;
	endtask : resetLow

	// Hold reset while the restarted clock settles
	task automatic settleRelease;
		int n;
		n = 0;
		while (n < SETTLE_CYC) begin
			@(posedge mclk);
			if (sysClkRun === 1'b1)
				n++;
		end
		pins.resetPin_n <= 1'b1;
	endtask : settleRelease

	// Standby and interrupt pins
	task automatic setStandby(input logic v);
		@(posedge mclk);
		pins.standbyPin_n <= v;
	endtask : setStandby
	task automatic setNmi(input logic v);
		@(posedge mclk);
		pins.nmiPin <= v;
	endtask : setNmi
	task automatic setIrq(input logic [15:0] v);
		@(posedge mclk);
		pins.extIrq <= v;
	endtask : setIrq

	// Mode pins never move during hardware standby
	task automatic setModePins(input logic [2:0] v);
		@(posedge mclk);
		while (mode === pwrdn_pkg::ST_HWSTBY)
			@(posedge mclk);
		pins.modePins <= v;
	endtask : setModePins
endmodule : pin_partner

// [bench/power_down_mode_control_bench.sv]
// Self-checking bench for the power-down mode controller.
// Assumes pin_partner drives the pins; one clock only.
`timescale 1ns/1ps
module power_down_mode_control_bench;
	localparam int LIMIT = 20000;
	logic             mclk, rst_n, ce, sleepExec, intAccepted, cpuIntMask;
	logic             mediumSpeedSel, busCycleEnd, xferBusReq, regWr, regRd;
	logic [15:0]      irqEnable;
	logic [3:0]       regAddr;
	logic [7:0]       regWrData, regRdData;
	logic [2:0]       bootMode;
	logic [23:0]      periphHalt, periphInit, periphRegEn;
	logic             cpuHalt, sysClkRun, chipReset, ioHighZ, got;
	logic             intExcStart, resetExcStart, mediumSpeed;
	pwrdn_pkg::mode_e mode;
	pwrdn_pkg::pins_s pins;
	pwrdn_pkg::ctl_s  ctl;
	int               errors = 0, checks = 0, cycles = 0, t0, el;

	pin_partner partner (.mclk, .mode, .sysClkRun, .pins);
	power_down_mode_control uut (.mclk, .rst_n, .ce, .pins, .sleepExec,
		.intAccepted, .cpuIntMask, .irqEnable, .mediumSpeedSel,
		.busCycleEnd, .xferBusReq, .regAddr, .regWrData, .regWr, .regRd,
		.regRdData, .mode, .cpuHalt, .sysClkRun, .chipReset, .ioHighZ,
		.intExcStart, .resetExcStart, .mediumSpeed, .bootMode, .ctl,
		.periphHalt, .periphInit, .periphRegEn);

	// Clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// Cycle count and hang limit
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			errors++;
			conclude();
		end
	end

	// Verdict
	task automatic conclude;
		if (errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	// Compare seen against expected
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			errors++;
			$display("unexpected at %0t: seen %0h expected %0h", $time,
				seen, want);
		end
	endtask : check

	// Register port cycles
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr   <= a;
		regWrData <= d;
		regWr     <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask : rd

	// Let cycles pass, then settle
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : idle

	// Wait for a pulse (0 interrupt, 1 reset) or a mode (2)
	task automatic waitUntil(input int w, input pwrdn_pkg::mode_e m,
		input int lim);
		int n;
		n = 0;
		got = 1'b0;
		while (got !== 1'b1 && n < lim) begin
			idle(1);
			n++;
			got = w == 0 ? intExcStart : w == 1 ? resetExcStart : mode === m;
		end
	endtask : waitUntil

	// Standby control write, then the sleep instruction
	task automatic sleepOp(input logic [7:0] c);
		wr(pwrdn_pkg::OFS_SLEEP_CTL, c);
		@(posedge mclk);
		sleepExec <= 1'b1;
		@(posedge mclk);
		sleepExec <= 1'b0;
		#1;
	endtask : sleepOp

	// Settling wait in clock cycles
	function automatic int settleCyc(input logic [2:0] s);
		return pwrdn_pkg::SETTLE_US[s] * pwrdn_pkg::CLK_MHZ;
	endfunction : settleCyc

	// Main sequence
	initial begin
		logic [7:0] d;
		logic [7:0] v;
		logic [2:0] s;
		int         k;
		int         i;
		void'($urandom(32'h3EC7));
		{rst_n, sleepExec, intAccepted, cpuIntMask, mediumSpeedSel} = '0;
		{busCycleEnd, xferBusReq, regWr, regRd, regAddr, regWrData} = '0;
		irqEnable = 16'h0000;
		ce = 1'b1;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		t0 = cycles;
		rd(pwrdn_pkg::OFS_STOP_HI, d);
		check(d, pwrdn_pkg::RST_STOP_HI);
		rd(pwrdn_pkg::OFS_STOP_SUB, d);
		check(d, 8'hFF);
		check(periphHalt, 24'hFF3FFF);
		check(mode, pwrdn_pkg::ST_RESET);
		waitUntil(1, pwrdn_pkg::ST_RUN, 400);
		check(got, 1'b1);
		check(cycles - t0 >= settleCyc(3'h0), 1'b1);
		// Unmapped places and read-only status
		for (k = 0; k < 3; k++) begin
			v = 8'($urandom_range(8, 15));
			wr(v[3:0], 8'($urandom));
			rd(v[3:0], d);
			check(d, 8'h00);
		end
		wr(pwrdn_pkg::OFS_STATUS, 8'hFF);
		rd(pwrdn_pkg::OFS_STATUS, d);
		check(d[2:0], pwrdn_pkg::ST_RUN);
		// Sleep and interrupt wake, normal and medium speed
		for (k = 0; k < 2; k++) begin
			@(posedge mclk);
			mediumSpeedSel <= k[0];
			cpuIntMask     <= 1'b1;
			sleepOp(8'h00);
			check({mode, cpuHalt}, {pwrdn_pkg::ST_SLEEP, 1'b1});
			partner.setIrq(16'hFFFF);
			idle(6);
			check(mode, pwrdn_pkg::ST_SLEEP);
			partner.setIrq(16'h0000);
			@(posedge mclk);
			cpuIntMask  <= 1'b0;
			intAccepted <= 1'b1;
			@(posedge mclk);
			intAccepted <= 1'b0;
			#1;
			check({mode, intExcStart}, {pwrdn_pkg::ST_RUN, 1'b1});
			check(mediumSpeed, k[0]);
		end
		// Subclock input enabled ahead of the standby entries
		wr(pwrdn_pkg::OFS_LOWPWR_CTL, 8'h10);
		rd(pwrdn_pkg::OFS_LOWPWR_CTL, d);
		check(d, 8'h10);
		// Software standby for settling choices 0, 1 and 7
		for (k = 0; k < 3; k++) begin
			s = k == 2 ? 3'h7 : 3'(k);
			wr(pwrdn_pkg::OFS_WDOG_CTL, 8'h40);
			sleepOp({1'b1, s, 4'h0});
			check(mode, pwrdn_pkg::ST_RUN);
			wr(pwrdn_pkg::OFS_WDOG_CTL, 8'h00);
			sleepOp({1'b1, s, 4'h0});
			check(mode, pwrdn_pkg::ST_SWSTBY);
			check({sysClkRun, cpuHalt}, 2'h1);
			i = $urandom_range(0, 15);
			@(posedge mclk);
			irqEnable <= ~(16'h0001 << i);
			partner.setIrq(16'h0001 << i);
			idle(8);
			check(mode, pwrdn_pkg::ST_SWSTBY);
			@(posedge mclk);
			irqEnable  <= 16'hFFFF;
			cpuIntMask <= 1'b1;
			idle(8);
			check(mode, pwrdn_pkg::ST_SWSTBY);
			@(posedge mclk);
			cpuIntMask <= 1'b0;
			#1 t0 = cycles;
			waitUntil(0, pwrdn_pkg::ST_RUN, settleCyc(s) + 20);
			el = cycles - t0;
			check(got, 1'b1);
			check(el >= settleCyc(s) && el <= settleCyc(s) + 10, 1'b1);
			partner.setIrq(16'h0000);
		end
		// Wake from software standby on each NMI edge choice
		for (k = 0; k < 2; k++) begin
			wr(pwrdn_pkg::OFS_SYS_CTL, 8'(k * 8 + 1));
			partner.setNmi(k[0]);
			idle(4);
			sleepOp(8'h80);
			partner.setNmi(!k[0]);
			idle(6);
			check(mode, pwrdn_pkg::ST_SWSTBY);
			partner.setNmi(k[0]);
			waitUntil(0, pwrdn_pkg::ST_RUN, settleCyc(3'h0) + 20);
			check(got, 1'b1);
		end
		// Reset pin from sleep and from software standby
		for (k = 0; k < 2; k++) begin
			sleepOp(k ? 8'h80 : 8'h00);
			partner.resetLow();
			waitUntil(2, pwrdn_pkg::ST_RESET, 6);
			check(got, 1'b1);
			check(sysClkRun, 1'b1);
			partner.settleRelease();
			waitUntil(1, pwrdn_pkg::ST_RUN, 10);
			check(got, 1'b1);
		end
		// Hardware standby entered from sleep
		v = 8'($urandom_range(0, 7));
		partner.setModePins(v[2:0]);
		wr(pwrdn_pkg::OFS_SYS_CTL, 8'h00);
		sleepOp(8'h00);
		partner.setStandby(1'b0);
		waitUntil(2, pwrdn_pkg::ST_HWSTBY, 6);
		check(got, 1'b1);
		check({ioHighZ, chipReset, cpuHalt}, 3'h7);
		wr(pwrdn_pkg::OFS_SLEEP_CTL, 8'hF0);
		#1;
		check(ctl.standbySelect, 1'b0);
		partner.resetLow();
		partner.setStandby(1'b1);
		waitUntil(2, pwrdn_pkg::ST_RESET, 6);
		check({got, sysClkRun}, 2'h3);
		partner.settleRelease();
		waitUntil(1, pwrdn_pkg::ST_RUN, 10);
		check(got, 1'b1);
		check(bootMode, v[2:0]);
		// Module stop takes effect at bus cycle end
		for (k = 0; k < 2; k++) begin
			v = k ? 8'h00 : 8'($urandom);
			d = periphHalt[7:0];
			wr(pwrdn_pkg::OFS_STOP_LO, v);
			idle(3);
			check(periphHalt[7:0], d);
			@(posedge mclk);
			busCycleEnd <= 1'b1;
			@(posedge mclk);
			busCycleEnd <= 1'b0;
			#1;
			check(periphHalt[7:0], v);
			check(periphInit[7:0], v & pwrdn_pkg::INIT_MASK[7:0]);
			check(periphRegEn[7:0], 8'(~v));
		end
		// Bus cycle end ignored while the clock enable is low
		wr(pwrdn_pkg::OFS_STOP_LO, 8'h5A);
		@(posedge mclk);
		ce          <= 1'b0;
		busCycleEnd <= 1'b1;
		idle(3);
		check(periphHalt[7:0], 8'h00);
		@(posedge mclk);
		ce <= 1'b1;
		@(posedge mclk);
		busCycleEnd <= 1'b0;
		#1;
		check(periphHalt[7:0], 8'h5A);
		// Stop write colliding with transfer controller request
		@(posedge mclk);
		xferBusReq <= 1'b1;
		wr(pwrdn_pkg::OFS_STOP_HI, 8'h7F);
		@(posedge mclk);
		xferBusReq <= 1'b0;
		rd(pwrdn_pkg::OFS_STOP_HI, d);
		check(d[6], 1'b0);
		wr(pwrdn_pkg::OFS_STOP_HI, 8'h7F);
		rd(pwrdn_pkg::OFS_STOP_HI, d);
		check(d[6], 1'b1);
		conclude();
	end
endmodule : power_down_mode_control_bench
